/* rtl/dub_pkg.sv */
/*
 * shared constants for the debug unlock / breakpoint / runtime counter unit.
 * assumes a single system clock; no software-visible registers.
 */
package dub_pkg;
  localparam logic [7:0]  AUTOBAUD_BYTE = 8'h80;
  localparam logic [7:0]  KEY_BYTE0     = 8'heb;
  localparam logic [7:0]  KEY_BYTE1     = 8'h5a;
  localparam logic [7:0]  KEY_BYTE2     = 8'h70;
  localparam logic [7:0]  KEY_BYTE3     = 8'hcd;
  localparam logic [7:0]  BRK_OPCODE    = 8'h00;
  localparam logic [7:0]  DBG_ENTER_CMD = 8'h80;
  localparam int          RUNTIME_WIDTH = 16;
  localparam logic [15:0] RUNTIME_MAX   = 16'hffff;
  localparam logic [15:0] RUNTIME_RESET = 16'h0000;
  localparam int          RESET_WAIT_MS = 5;
  localparam int          CLK_HZ        = 20000000;
  localparam int          RESET_WAIT_CYC = RESET_WAIT_MS * (CLK_HZ / 1000);

  typedef enum logic [2:0] {
    DUB_UL_WAIT_AB = 3'b000,
    DUB_UL_KEY0    = 3'b001,
    DUB_UL_KEY1    = 3'b011,
    DUB_UL_KEY2    = 3'b010,
    DUB_UL_KEY3    = 3'b110,
    DUB_UL_ARMED   = 3'b111,
    DUB_UL_FAIL    = 3'b101
  } dub_unlock_t;

  function automatic logic [7:0] dub_key_byte(input dub_unlock_t s);
    case (s)
      DUB_UL_WAIT_AB: dub_key_byte = AUTOBAUD_BYTE;
      DUB_UL_KEY0:    dub_key_byte = KEY_BYTE0;
      DUB_UL_KEY1:    dub_key_byte = KEY_BYTE1;
      DUB_UL_KEY2:    dub_key_byte = KEY_BYTE2;
      DUB_UL_KEY3:    dub_key_byte = KEY_BYTE3;
      default:        dub_key_byte = 8'h00;
    endcase
  endfunction
endpackage

/* rtl/dub_debug_unit.sv */
/*
 * debug unit: pin unlock sequence, breakpoint handling, runtime counter.
 * assumes an external serial front end delivers received debug bytes as
 * RX_VALID/RX_DATA strobes, and that the debug command decoder reports
 * debug-mode entry/exit requests as pulses. SYS_CLK 20 MHz, RST_B async.
 */
// Overview of operation
// - small package keeps the shared pin gpio unless unlocked in reset.
// - release after a good key gives the shared pin full debug function.
// - the breakpoint instruction is opcode 00h and its decode signals us.
// - with breakpoints enabled a breakpoint enters debug, idles the cpu.
// - with breakpoints disabled a breakpoint is a no-op, but drops an enter command in the same cycle.
// - a 16-bit runtime counter counts system clocks between breakpoints.
// - counter starts on debug exit, stops on entry or at ffffh, no wrap.
`timescale 1ns/1ns
module dub_debug_unit
  import dub_pkg::*;
#(
  parameter int RUN_W = RUNTIME_WIDTH
) (
  input  wire logic             SYS_CLK,
  input  wire logic             RST_B,
  input  wire logic             SMALL_PKG,
  input  wire logic             RESET_PIN_LOW,
  input  wire logic             RX_VALID,
  input  wire logic [7:0]       RX_DATA,
  input  wire logic             OPCODE_VALID,
  input  wire logic [7:0]       OPCODE,
  input  wire logic             BRK_ENABLE,
  input  wire logic             DBG_CMD_VALID,
  input  wire logic [7:0]       DBG_CMD_DATA,
  input  wire logic             DBG_EXIT,
  output logic                  DEBUG_PIN_EN,
  output logic                  DEBUG_MODE,
  output logic                  CPU_IDLE,
  output logic                  BRK_NOP,
  output logic [RUN_W-1:0]      RUNTIME_COUNT
);

  // key walk state and the pin that it unlocks
  dub_unlock_t            ul_q;
  dub_unlock_t            ul_d;
  logic                   pin_en_q;
  logic                   pin_en_d;

  // debug mode and the one-cycle no-op pulse
  logic                   dbg_q;
  logic                   dbg_d;
  logic                   nop_q;
  logic                   nop_d;

  // runtime counter
  logic                   run_q;
  logic                   run_d;
  logic [RUN_W-1:0]       cnt_q;
  logic [RUN_W-1:0]       cnt_d;

  // decoded events
  logic                   ul_listen;
  logic                   ul_byte_ok;
  logic                   brk_hit;
  logic                   brk_take;
  logic                   cmd_enter;
  logic                   exit_req;
  logic                   dbg_leave;
  logic                   cnt_full;

  // all ones at any width, so a wider counter still saturates
  localparam logic [RUN_W-1:0] CNT_TOP  = {RUN_W{1'b1}};
  localparam logic [RUN_W-1:0] CNT_ZERO = RUN_W'(RUNTIME_RESET);

  // next step of the key walk; anything off the usual path fails
  function automatic dub_unlock_t ul_next(input dub_unlock_t s);
    case (s)
      DUB_UL_WAIT_AB: begin
        ul_next = DUB_UL_KEY0;
      end
      DUB_UL_KEY0: begin
        ul_next = DUB_UL_KEY1;
      end
      DUB_UL_KEY1: begin
        ul_next = DUB_UL_KEY2;
      end
      DUB_UL_KEY2: begin
        ul_next = DUB_UL_KEY3;
      end
      DUB_UL_KEY3: begin
        ul_next = DUB_UL_ARMED;
      end
      default: begin
        ul_next = DUB_UL_FAIL;
      end
    endcase
  endfunction

  // unlock sequencer; only listens while the reset pin is held low.
  // armed and failed are sinks until the whole chip is reset
  assign ul_listen  = RESET_PIN_LOW && RX_VALID
                      && ul_q != DUB_UL_ARMED && ul_q != DUB_UL_FAIL;
  assign ul_byte_ok = RX_DATA == dub_key_byte(ul_q);

  always_comb begin
    ul_d = ul_q;
    if (ul_listen) begin
      if (ul_byte_ok) begin
        ul_d = ul_next(ul_q);
      end else begin
        ul_d = DUB_UL_FAIL;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ul_q <= DUB_UL_WAIT_AB;
    end else begin
      ul_q <= ul_d;
    end
  end

  // pin function; a large package never needs the key
  always_comb begin
    pin_en_d = pin_en_q;
    if (RESET_PIN_LOW) begin
      pin_en_d = !SMALL_PKG;
    end else if (ul_q == DUB_UL_ARMED) begin
      // released after a full key: pin becomes the debug pin
      pin_en_d = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_en_q <= 1'b0;
    end else begin
      pin_en_q <= pin_en_d;
    end
  end

  // breakpoints only count outside debug mode
  assign brk_hit   = OPCODE_VALID && OPCODE == BRK_OPCODE;
  assign brk_take  = brk_hit && !dbg_q;
  assign cmd_enter = pin_en_q && DBG_CMD_VALID
                     && DBG_CMD_DATA == DBG_ENTER_CMD;
  assign exit_req  = DBG_EXIT && dbg_q;

  // priority: breakpoint, then command, then exit
  always_comb begin
    dbg_d = dbg_q;
    if (brk_take) begin
      if (BRK_ENABLE) begin
        dbg_d = 1'b1;
      end
    end else if (cmd_enter) begin
      dbg_d = 1'b1;
    end else if (exit_req) begin
      dbg_d = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dbg_q <= 1'b0;
    end else begin
      dbg_q <= dbg_d;
    end
  end

  // disabled breakpoint: one pulse, the cpu carries on
  always_comb begin
    nop_d = 1'b0;
    if (brk_take && !BRK_ENABLE) begin
      nop_d = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      nop_q <= 1'b0;
    end else begin
      nop_q <= nop_d;
    end
  end

  // runtime counter; idle after reset until the first debug exit
  assign dbg_leave = dbg_q && !dbg_d;
  assign cnt_full  = cnt_q == CNT_TOP;

  always_comb begin
    run_d = run_q;
    if (dbg_leave) begin
      run_d = 1'b1;
    end else if (dbg_d) begin
      run_d = 1'b0;
    end else if (run_q && cnt_full) begin
      run_d = 1'b0;
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (dbg_leave) begin
      // restart from zero so each reading spans one run
      cnt_d = CNT_ZERO;
    end else if (run_q && !dbg_d && !cnt_full) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_q <= 1'b0;
      cnt_q <= CNT_ZERO;
    end else begin
      run_q <= run_d;
      cnt_q <= cnt_d;
    end
  end

  // outputs are plain copies of flip-flops
  always_comb begin
    DEBUG_PIN_EN  = pin_en_q;
    DEBUG_MODE    = dbg_q;
    CPU_IDLE      = dbg_q;
    BRK_NOP       = nop_q;
    RUNTIME_COUNT = cnt_q;
  end

endmodule

/* tb/dub_checker.sv */
/* debug unit port checker.
   bound to the top module by the bench. */
`timescale 1ns/1ns
module dub_checker
  import dub_pkg::*;
(input wire logic SYS_CLK, RST_B, SMALL_PKG, RESET_PIN_LOW, OPCODE_VALID,
 input wire logic BRK_ENABLE, DBG_EXIT, BRK_NOP, DEBUG_PIN_EN, DEBUG_MODE,
 input wire logic CPU_IDLE,
 input wire logic [7:0] OPCODE,
 input wire logic [15:0] RUNTIME_COUNT);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  wire hit = OPCODE_VALID && OPCODE == BRK_OPCODE && !DEBUG_MODE;
  wire [15:0] n = RUNTIME_COUNT;
  property p_gpio; SMALL_PKG && RESET_PIN_LOW |=> !DEBUG_PIN_EN; endproperty
  a_gpio: assert property (p_gpio) else $error("pin on");
  property p_lock; SMALL_PKG && !(DEBUG_PIN_EN || RESET_PIN_LOW ||
    $past(RESET_PIN_LOW)) |=> !DEBUG_PIN_EN; endproperty
  a_lock: assert property (p_lock) else $error("unlocked");
  property p_hold; DEBUG_PIN_EN && !RESET_PIN_LOW |=> DEBUG_PIN_EN;
  endproperty
  a_hold: assert property (p_hold) else $error("pin lost");
  property p_brk; hit && BRK_ENABLE |=> DEBUG_MODE && CPU_IDLE; endproperty
  a_brk: assert property (p_brk) else $error("no entry");
  property p_nop; hit && !BRK_ENABLE |=> BRK_NOP && !CPU_IDLE ##1 !BRK_NOP;
  endproperty
  a_nop: assert property (p_nop) else $error("no nop");
  property p_exit; DEBUG_MODE && DBG_EXIT |=> n == 16'h0 ##1 n == 16'h1;
  endproperty
  a_exit: assert property (p_exit) else $error("bad start");
  property p_run; !DEBUG_MODE && n != 16'h0 && n != RUNTIME_MAX |=>
    DEBUG_MODE || n == $past(n) + 16'h1; endproperty
  a_run: assert property (p_run) else $error("bad count");
  property p_sat; n == RUNTIME_MAX && !DBG_EXIT |=> n == RUNTIME_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("wrapped");
  c_brk: cover property (hit && BRK_ENABLE);
  c_nop: cover property (BRK_NOP);
  c_sat: cover property (n == RUNTIME_MAX);
endmodule

/* tb/dub_host.sv */
/* debug host model: unlock bytes on the serial side.
   assumes unlock is called just after a rising edge. */
`timescale 1ns/1ns
module dub_host import dub_pkg::*;
(input wire logic clk, output logic pin_low, vld, output logic [7:0] dat);
  initial {pin_low, vld, dat} = 10'h0;
  // bad spoils the third key byte; gap 0 sends back to back
  task automatic unlock(input logic bad, input int gap);
    logic [7:0] k [5];
    k = '{AUTOBAUD_BYTE, KEY_BYTE0, KEY_BYTE1, KEY_BYTE2, KEY_BYTE3};
    k[3] = bad ? ~KEY_BYTE2 : KEY_BYTE2;
    pin_low <= 1'b1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      {vld, dat} <= {1'b1, k[i]};
      @(posedge clk);
      if (gap > 0 || i == 4) {vld, dat} <= {1'b0, ~k[i]};
      repeat (gap) @(posedge clk);
    end
    pin_low <= 1'b0;
    @(posedge clk);
  endtask
endmodule

/* tb/dub_debug_unit_tb.sv */
/* bench for the debug unit.
   assumes dub_host on the serial side. */
`timescale 1ns/1ns
module dub_debug_unit_tb import dub_pkg::*;;
  logic c, rb, sp, ov, be, cv, dx, pe, dm, ci, bn, pl, rv;
  logic [7:0] op, cd, rd;
  logic [15:0] rc;
  int failures, total_checks;
  dub_host host_u (.clk(c), .pin_low(pl), .vld(rv), .dat(rd));
  dub_debug_unit dut_u (.SYS_CLK(c), .RST_B(rb), .SMALL_PKG(sp),
    .RESET_PIN_LOW(pl), .RX_VALID(rv), .RX_DATA(rd), .OPCODE_VALID(ov),
    .OPCODE(op), .BRK_ENABLE(be), .DBG_CMD_VALID(cv), .DBG_CMD_DATA(cd),
    .DBG_EXIT(dx), .DEBUG_PIN_EN(pe), .DEBUG_MODE(dm), .CPU_IDLE(ci),
    .BRK_NOP(bn), .RUNTIME_COUNT(rc));
  initial begin c = 0; forever #25 c = ~c; end
  task chk(input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask
  task give_verdict;
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task rst;
    @(posedge c); rb <= 0; repeat (5) @(posedge c); rb <= 1; @(posedge c);
  endtask
  // w: 2 opcode, 1 command, 0 exit; looks just after the taking edge
  task go(input int w, input logic [7:0] d, input logic b);
    @(posedge c); {ov, cv, dx} <= 3'h1 << w; {op, cd, be} <= {d, d, b};
    @(posedge c); {ov, cv, dx} <= 3'h0; #1;
  endtask
  task t_unlock;
    host_u.unlock(1, 2); #1 chk(pe, 0);
    go(1, DBG_ENTER_CMD, 0); chk(dm, 0);
    rst; host_u.unlock(0, 0); #1 chk(pe, 1);
    go(1, DBG_ENTER_CMD, 0); chk(ci, 1);
  endtask
  task t_brk; // count from exit, no entry on other opcodes, freeze
    go(0, 8'h0, 1); repeat (9) @(posedge c); #1 chk(rc, 16'h9);
    go(2, 8'h0f, 1); chk(dm, 0);
    go(2, BRK_OPCODE, 1); chk(ci, 1);
    repeat (4) @(posedge c); #1 chk(rc, 16'hc);
  endtask
  task t_sat; // disabled breakpoint is a no-op, count stops at the top
    go(0, 8'h0, 0); go(2, BRK_OPCODE, 0); chk({bn, dm}, 2'b10);
    repeat (65540) @(posedge c); #1 chk(rc, RUNTIME_MAX);
  endtask
  task t_large; // large package: pin works without the key
    @(posedge c); sp <= 0; rst;
    host_u.unlock(1, 0); #1 chk(pe, 1);
    go(1, DBG_ENTER_CMD, 0); chk(dm, 1);
  endtask
  initial begin
    {rb, ov, be, cv, dx, op, cd} <= '0; sp <= 1;
    rst; t_unlock; t_brk; t_sat; t_large; give_verdict;
  end
endmodule
bind dub_debug_unit dub_checker chk_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
  .SMALL_PKG(SMALL_PKG), .RESET_PIN_LOW(RESET_PIN_LOW),
  .OPCODE_VALID(OPCODE_VALID), .BRK_ENABLE(BRK_ENABLE),
  .DBG_EXIT(DBG_EXIT), .BRK_NOP(BRK_NOP), .DEBUG_PIN_EN(DEBUG_PIN_EN),
  .DEBUG_MODE(DEBUG_MODE), .CPU_IDLE(CPU_IDLE), .OPCODE(OPCODE),
  .RUNTIME_COUNT(RUNTIME_COUNT));
